// ---- core/tacc_control.v ----
/*
 * Touch converter control: register file, channel decode, panel switch and
 * reference routing, power control, conversion sequencing and the shared
 * interrupt pin.
 * Assumes a register write port already decoded from the serial interface
 * and a converter that answers each start with a done pulse.
 */
`timescale 1ns/10ps
`include "tacc_regs.vh"

module tacc_control #(
	parameter STEP_CYC = `TACC_FCD_STEP_CYC
) (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        reg_write,
	input  wire        reg_read,
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	input  wire        panel_touched,
	input  wire        aux_low_event,
	input  wire        aux_high_event,
	input  wire        temp_low_event,
	input  wire        temp_high_event,
	input  wire        gpio_alert_event,
	input  wire        adc_done,
	output reg         adc_start,
	output reg  [2:0]  channel_select,
	output reg         x_pos_drive,
	output reg         x_neg_drive,
	output reg         y_pos_drive,
	output reg         y_neg_drive,
	output reg  [1:0]  ref_pos_sel,
	output reg  [1:0]  ref_neg_sel,
	output reg         adc_power,
	output reg         osc_power,
	output reg         bias_power,
	output reg         temp_power,
	output reg         pen_down_request_n,
	output reg         conv_busy
);
	localparam ST_IDLE   = 3'd0;
	localparam ST_WAIT   = 3'd1;
	localparam ST_PICK   = 3'd2;
	localparam ST_SETTLE = 3'd3;
	localparam ST_CONV   = 3'd4;
	localparam ST_TAIL   = 3'd5;

	reg [15:0] ctrl1;
	reg [15:0] analog_power_config;
	reg [15:0] interrupt_sequence_config;
	reg [2:0]  state;
	reg [7:0]  pending;
	reg        first_done;
	reg        alarm_any;
	reg        dly_start;
	wire [2:0] next_chan;
	wire       dly_busy;
	wire       dly_done;

	wire [1:0] power_mode_bits          = analog_power_config[`TACC_PM_HI:`TACC_PM_LO];
	wire       conversion_method_select = analog_power_config[`TACC_BIT_METHOD];
	wire [3:0] first_conv_delay         = analog_power_config[`TACC_FCD_HI:`TACC_FCD_LO];
	wire [1:0] conv_mode                = ctrl1[`TACC_MODE_HI:`TACC_MODE_LO];
	wire       pen_disable              = ctrl1[`TACC_BIT_PEN_DISABLE];

	// Coordinate channels need the panel settling delay.
	function is_coord;
		input [2:0] ch;
		begin
			is_coord = (ch == `TACC_CH_XPOS) || (ch == `TACC_CH_YPOS);
		end
	endfunction

	// Highest pending sequence bit picks the next channel; bit 0 is unused.
	function [2:0] first_pending;
		input [7:0] p;
		integer i;
		begin
			first_pending = `TACC_CH_NONE;
			for (i = 1; i < 8; i = i + 1) begin
				if (p[i])
					first_pending = i[2:0];
			end
		end
	endfunction

	// Channel that the sequencer takes next from the pending bits.
	assign next_chan = first_pending(pending);

	tacc_delay_timer #(
		.STEP_CYC (STEP_CYC)
	) u_delay (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (dly_start),
		.code    (first_conv_delay),
		.busy    (dly_busy),
		.done    (dly_done)
	);

	// Register writes, and sticky limit status bits where hardware set wins.
	always @(posedge clk) begin
		if (!reset_n) begin
			ctrl1                     <= `TACC_CTRL1_RESET;
			analog_power_config       <= `TACC_POWER_RESET;
			interrupt_sequence_config <= `TACC_INTSEQ_RESET;
		end else begin
			if (reg_write && reg_addr == `TACC_OFF_CTRL1)
				ctrl1 <= reg_wdata;
			else if (state == ST_TAIL && dly_done && ctrl1[7:0] == 8'h00 &&
				conv_mode != `TACC_MODE_MASTER)
				ctrl1[`TACC_MODE_HI:`TACC_MODE_LO] <= `TACC_MODE_IDLE;
			if (reg_write && reg_addr == `TACC_OFF_POWER)
				analog_power_config <= reg_wdata;
			if (reg_write && reg_addr == `TACC_OFF_INTSEQ)
				interrupt_sequence_config <= reg_wdata;
			if (gpio_alert_event)
				interrupt_sequence_config[`TACC_BIT_GPIO_ALERT] <= 1'b1;
			if (aux_low_event)
				interrupt_sequence_config[`TACC_BIT_AUX_LOW] <= 1'b1;
			if (aux_high_event)
				interrupt_sequence_config[`TACC_BIT_AUX_HIGH] <= 1'b1;
			if (temp_low_event)
				interrupt_sequence_config[`TACC_BIT_TEMP_LOW] <= 1'b1;
			if (temp_high_event)
				interrupt_sequence_config[`TACC_BIT_TEMP_HIGH] <= 1'b1;
		end
	end

	// Read mux; unmapped offsets read zero.
	always @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read) begin
			case (reg_addr)
				`TACC_OFF_CTRL1:  reg_rdata <= ctrl1;
				`TACC_OFF_POWER:  reg_rdata <= analog_power_config;
				`TACC_OFF_INTSEQ: reg_rdata <= interrupt_sequence_config;
				default:          reg_rdata <= 16'h0000;
			endcase
		end
	end

	// Masked limit sources and the unmasked GPIO alert combine into one alarm level.
	always @* begin
		alarm_any = interrupt_sequence_config[`TACC_BIT_GPIO_ALERT] |
			(~interrupt_sequence_config[`TACC_BIT_AUX_MASK] &
			 (interrupt_sequence_config[`TACC_BIT_AUX_LOW] |
			  interrupt_sequence_config[`TACC_BIT_AUX_HIGH])) |
			(~interrupt_sequence_config[`TACC_BIT_TEMP_MASK] &
			 (interrupt_sequence_config[`TACC_BIT_TEMP_LOW] |
			  interrupt_sequence_config[`TACC_BIT_TEMP_HIGH]));
	end

	// Conversion sequencer: touch wait, settle delays, conversions, tail delay.
	always @(posedge clk) begin
		if (!reset_n) begin
			state      <= ST_IDLE;
			pending    <= 8'h00;
			first_done <= 1'b0;
			dly_start  <= 1'b0;
			adc_start  <= 1'b0;
			channel_select <= `TACC_CH_NONE;
		end else begin
			dly_start <= 1'b0;
			adc_start <= 1'b0;
			case (state)
				ST_IDLE: begin
					first_done <= 1'b0;
					if (power_mode_bits == `TACC_PM_OFF) begin
						state <= ST_IDLE;
					end else if (conv_mode == `TACC_MODE_MASTER) begin
						state <= ST_WAIT;
					end else if (conv_mode == 2'h1) begin
						pending <= 8'h01 << ctrl1[`TACC_CHAN_HI:`TACC_CHAN_LO];
						state   <= ST_PICK;
					end else if (conv_mode == 2'h2) begin
						pending <= {interrupt_sequence_config[7:1], 1'b0};
						state   <= ST_PICK;
					end
				end
				ST_WAIT: begin
					if (conv_mode != `TACC_MODE_MASTER ||
						power_mode_bits == `TACC_PM_OFF)
						state <= ST_IDLE;
					else if (panel_touched) begin
						pending <= {interrupt_sequence_config[7:1], 1'b0};
						state   <= ST_PICK;
					end
				end
				ST_PICK: begin
					if (next_chan == `TACC_CH_NONE) begin
						dly_start <= 1'b1;
						state     <= ST_TAIL;
					end else begin
						channel_select <= next_chan;
						pending[next_chan] <= 1'b0;
						if (!first_done || is_coord(next_chan)) begin
							dly_start <= 1'b1;
							state     <= ST_SETTLE;
						end else begin
							adc_start <= 1'b1;
							state     <= ST_CONV;
						end
					end
				end
				ST_SETTLE: begin
					if (dly_done) begin
						adc_start <= 1'b1;
						state     <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (adc_done) begin
						first_done <= 1'b1;
						state      <= ST_PICK;
					end
				end
				ST_TAIL: begin
					if (dly_done)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
			if (power_mode_bits == `TACC_PM_OFF) begin
				state     <= ST_IDLE;
				adc_start <= 1'b0;
			end
		end
	end

	// Switch and reference routing per channel and method.
	always @(posedge clk) begin
		if (!reset_n) begin
			x_pos_drive <= 1'b0;
			x_neg_drive <= 1'b0;
			y_pos_drive <= 1'b0;
			y_neg_drive <= 1'b0;
			ref_pos_sel <= 2'h0;
			ref_neg_sel <= 2'h0;
		end else begin
			x_pos_drive <= 1'b0;
			x_neg_drive <= 1'b0;
			y_pos_drive <= 1'b0;
			y_neg_drive <= 1'b0;
			ref_pos_sel <= 2'h0; // Supply rail.
			ref_neg_sel <= 2'h0; // Ground.
			if (state == ST_PICK || state == ST_SETTLE || state == ST_CONV) begin
				case ((state == ST_PICK) ? next_chan : channel_select)
					`TACC_CH_XPOS: begin
						y_pos_drive <= 1'b1;
						y_neg_drive <= 1'b1;
						if (!conversion_method_select) begin
							ref_pos_sel <= 2'h2; // Y+ node.
							ref_neg_sel <= 2'h2; // Y- node.
						end
					end
					`TACC_CH_YPOS: begin
						x_pos_drive <= 1'b1;
						x_neg_drive <= 1'b1;
						if (!conversion_method_select) begin
							ref_pos_sel <= 2'h1; // X+ node.
							ref_neg_sel <= 2'h1; // X- node.
						end
					end
					`TACC_CH_Z1, `TACC_CH_Z2: begin
						if (!conversion_method_select) begin
							x_neg_drive <= 1'b1;
							y_pos_drive <= 1'b1;
							ref_pos_sel <= 2'h2; // Y+ node.
							ref_neg_sel <= 2'h1; // X- node.
						end
					end
					default: ref_pos_sel <= 2'h0;
				endcase
			end
		end
	end

	// Power control; shutdown overrides every conversion mode.
	always @(posedge clk) begin
		if (!reset_n) begin
			adc_power  <= 1'b0;
			osc_power  <= 1'b0;
			bias_power <= 1'b0;
			temp_power <= 1'b0;
		end else if (power_mode_bits == `TACC_PM_OFF) begin
			adc_power  <= 1'b0;
			osc_power  <= 1'b0;
			bias_power <= 1'b0;
			temp_power <= 1'b0;
		end else if (power_mode_bits == `TACC_PM_ON) begin
			adc_power  <= 1'b1;
			osc_power  <= 1'b1;
			bias_power <= 1'b1;
			temp_power <= (state != ST_IDLE && state != ST_WAIT);
		end else if (conv_mode == `TACC_MODE_MASTER) begin
			adc_power  <= (state != ST_IDLE && state != ST_WAIT);
			osc_power  <= (state != ST_IDLE && state != ST_WAIT);
			bias_power <= (state != ST_IDLE && state != ST_WAIT);
			temp_power <= (state != ST_IDLE && state != ST_WAIT);
		end else begin
			adc_power  <= (state != ST_IDLE);
			osc_power  <= 1'b1;
			bias_power <= 1'b1;
			temp_power <= (state != ST_IDLE);
		end
	end

	// Shared pin: pen down when enabled, else limit alarm; low is active.
	always @(posedge clk) begin
		if (!reset_n) begin
			pen_down_request_n <= 1'b1;
			conv_busy          <= 1'b0;
		end else begin
			conv_busy <= (state != ST_IDLE && state != ST_WAIT);
			if (!pen_disable)
				pen_down_request_n <= ~panel_touched;
			else
				pen_down_request_n <= ~alarm_any;
		end
	end
endmodule

// ---- pkg/tacc_regs.vh ----
/*
 * Register offsets, field positions, reset values and timing counts for
 * the touch converter control block.
 * Assumes a 100 MHz core clock and 16-bit registers at word offsets.
 */
`ifndef TACC_REGS_VH
`define TACC_REGS_VH

`define TACC_OFF_CTRL1          4'h1
`define TACC_OFF_POWER          4'h2
`define TACC_OFF_INTSEQ         4'h3

`define TACC_CTRL1_RESET        16'h0000
`define TACC_POWER_RESET        16'h4040
`define TACC_INTSEQ_RESET       16'h0000

`define TACC_BIT_PEN_DISABLE    15
`define TACC_CHAN_HI            14
`define TACC_CHAN_LO            12
`define TACC_MODE_HI            11
`define TACC_MODE_LO            10
`define TACC_PM_HI              15
`define TACC_PM_LO              14
`define TACC_BIT_METHOD         9
`define TACC_FCD_HI             3
`define TACC_FCD_LO             0

`define TACC_BIT_TEMP_MASK      15
`define TACC_BIT_AUX_MASK       14
`define TACC_BIT_INT_MODE       13
`define TACC_BIT_GPIO_ALERT     12
`define TACC_BIT_AUX_LOW        11
`define TACC_BIT_AUX_HIGH       10
`define TACC_BIT_TEMP_LOW       9
`define TACC_BIT_TEMP_HIGH      8

`define TACC_CH_XPOS            3'h7
`define TACC_CH_YPOS            3'h6
`define TACC_CH_Z1              3'h5
`define TACC_CH_Z2              3'h4
`define TACC_CH_AUX             3'h3
`define TACC_CH_BAT             3'h2
`define TACC_CH_TEMP            3'h1
`define TACC_CH_NONE            3'h0

`define TACC_MODE_IDLE          2'h0
`define TACC_MODE_MASTER        2'h3

`define TACC_PM_OFF             2'h0
`define TACC_PM_ON              2'h2

`define TACC_CLK_MHZ            100
`define TACC_FCD_STEP_US        128
`define TACC_FCD_STEP_CYC       (`TACC_FCD_STEP_US * `TACC_CLK_MHZ)

`endif

// ---- core/tacc_delay_timer.v ----
/*
 * First conversion delay timer: counts the programmed delay once started.
 * Assumes the delay code is stable while the timer runs.
 */
`timescale 1ns/10ps
`include "tacc_regs.vh"

module tacc_delay_timer #(
	parameter STEP_CYC = `TACC_FCD_STEP_CYC
) (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        start,
	input  wire [3:0]  code,
	output reg         busy,
	output reg         done
);
	reg  [19:0] count;
	wire [31:0] load_count;

	// Number of 128 us steps for each code.
	function [5:0] steps;
		input [3:0] c;
		begin
			case (c)
				4'hA:    steps = 6'd12;
				4'hB:    steps = 6'd14;
				4'hC:    steps = 6'd16;
				4'hD:    steps = 6'd20;
				4'hE:    steps = 6'd28;
				4'hF:    steps = 6'd32;
				default: steps = {2'b00, c} + 6'd1;
			endcase
		end
	endfunction

	// Full delay in cycles, less one because the zero count takes a cycle too.
	assign load_count = steps(code) * STEP_CYC - 1;

	// Load the count on start and flag completion for one cycle.
	always @(posedge clk) begin
		if (!reset_n) begin
			count <= 20'h00000;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count <= load_count[19:0];
				busy  <= 1'b1;
			end else if (busy) begin
				if (count == 20'h00000) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 20'h00001;
				end
			end
		end
	end
endmodule

// ---- verification/tacc_panel_model.sv ----
/* Panel and converter model for the touch converter control block.
   Assumes the bench drives touch and slow after falling clock edges. */
`timescale 1ns/10ps
module tacc_panel_model (
	input  wire logic clk,
	input  wire logic touch,
	input  wire logic slow,
	input  wire logic adc_start,
	output wire logic panel_touched,
	output logic      adc_done
);
	logic [3:0] cnt = 4'h0;

	// The panel reports contact as a plain level.
	assign panel_touched = touch;

	// Each start gets one done pulse, after a short or a long conversion.
	always @(posedge clk) begin
		adc_done <= (cnt == 4'h1);
		if (adc_start)
			cnt <= slow ? 4'h9 : 4'h2;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
endmodule

// ---- verification/tacc_properties.sv ----
/* Port checker for the touch converter control block.
   Assumes it is bound to tacc_control and sees only its ports. */
`timescale 1ns/10ps
`include "tacc_regs.vh"
module tacc_properties #(
	parameter STEP_CYC = `TACC_FCD_STEP_CYC
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        panel_touched,
	input wire logic        aux_low_event,
	input wire logic        aux_high_event,
	input wire logic        temp_low_event,
	input wire logic        temp_high_event,
	input wire logic        gpio_alert_event,
	input wire logic        adc_done,
	input wire logic        adc_start,
	input wire logic [2:0]  channel_select,
	input wire logic        x_pos_drive,
	input wire logic        x_neg_drive,
	input wire logic        y_pos_drive,
	input wire logic        y_neg_drive,
	input wire logic [1:0]  ref_pos_sel,
	input wire logic [1:0]  ref_neg_sel,
	input wire logic        adc_power,
	input wire logic        osc_power,
	input wire logic        bias_power,
	input wire logic        temp_power,
	input wire logic        pen_down_request_n,
	input wire logic        conv_busy
);
	logic       pen_off, method, alarm;
	logic [1:0] pm;
	int         wt;

	// Shadow copies of the bits that steer the pin, power and routing.
	always @(posedge clk) begin
		if (!reset_n) begin
			pen_off <= 1'b0;
			pm <= 2'h1;
			method <= 1'b0;
			alarm <= 1'b0;
		end else begin
			if (reg_write && reg_addr == `TACC_OFF_CTRL1)
				pen_off <= reg_wdata[15];
			if (reg_write && reg_addr == `TACC_OFF_POWER) begin
				pm <= reg_wdata[15:14];
				method <= reg_wdata[9];
			end
			if (aux_low_event | aux_high_event | temp_low_event | temp_high_event | gpio_alert_event)
				alarm <= 1'b1;
			if (reg_write && reg_addr == `TACC_OFF_INTSEQ && reg_wdata[12:8] != 5'h00)
				alarm <= 1'b1;
		end
	end

	// Cycles spent busy since the sequence was launched.
	always @(posedge clk) begin
		wt <= (!reset_n || !conv_busy) ? 0 : wt + 1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_launch;
		$rose(conv_busy);
	endsequence
	sequence s_first_start;
		##[4:300] adc_start;
	endsequence

	a_pen_shows_touch: assert property (
		(!pen_off && panel_touched && !conv_busy) [*2] |=> !pen_down_request_n)
		else $error("Pin stays high while touched");
	a_pen_suppressed: assert property (
		pen_off && $past(pen_off) && !alarm |-> pen_down_request_n)
		else $error("Pin low with pen output off");
	a_pressure_route: assert property (
		adc_start && !method && channel_select inside {3'h5, 3'h4} |->
		{x_pos_drive, x_neg_drive, y_pos_drive, y_neg_drive, ref_pos_sel, ref_neg_sel} == 8'h69)
		else $error("Pressure routing wrong");
	a_single_ended_ref: assert property (
		adc_start && method |-> ref_pos_sel == 2'h0 && ref_neg_sel == 2'h0)
		else $error("Single-ended references wrong");
	a_shutdown_all_off: assert property (
		pm == 2'h0 && $past(pm) == 2'h0 |->
		!(adc_power | osc_power | bias_power | temp_power | adc_start))
		else $error("Activity in shutdown");
	a_full_power_on: assert property (
		pm == 2'h2 && $past(pm) == 2'h2 |-> adc_power && osc_power && bias_power)
		else $error("Power mode two not on");
	a_first_delay: assert property (
		adc_start && conv_busy |-> wt >= STEP_CYC)
		else $error("Conversion before delay");
	a_launch_start: assert property (
		s_launch |-> s_first_start)
		else $error("No conversion after launch");
	a_tail_delay: assert property (
		adc_done && conv_busy |=> conv_busy [*4])
		else $error("No tail delay");
	a_unmapped_read: assert property (
		reg_read && (reg_addr == 4'h0 || reg_addr > 4'h3) |=> reg_rdata == 16'h0000)
		else $error("Unmapped read not zero");
endmodule

bind tacc_control tacc_properties #(.STEP_CYC(STEP_CYC)) chk (.*);

// ---- verification/touch_adc_conversion_control_test.sv ----
/* Bench for the touch converter control block with panel model.
   Assumes the register header is on the include path. */
`timescale 1ns/10ps
`include "tacc_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("Error %0t: got %h, expected %h", $time, (a), (b)); end end
`define WAIT(c) begin for (k = 0; k < 500 && !(c); k++) @(negedge clk); \
	if (!(c)) begin miscompares++; $display("Error %0t: wait timed out", $time); end end
module touch_adc_conversion_control_test;
	logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, touch = 0, slow = 0;
	logic aux_low_event = 0, aux_high_event = 0, temp_low_event = 0;
	logic temp_high_event = 0, gpio_alert_event = 0;
	logic [3:0]  reg_addr = 0;
	logic [15:0] reg_wdata = 0, d;
	wire  [15:0] reg_rdata;
	wire  [2:0]  channel_select;
	wire  [1:0]  ref_pos_sel, ref_neg_sel;
	wire panel_touched, adc_done, adc_start, x_pos_drive, x_neg_drive, y_pos_drive;
	wire y_neg_drive, adc_power, osc_power, bias_power, temp_power, pen_down_request_n;
	wire conv_busy;
	int  miscompares = 0, n_tests = 0, k;
	time t0;
	// Method, channel, then drives x+ x- y+ y- and reference selects.
	logic [11:0] rows[14] = '{
		12'b0_111_0011_1010, 12'b0_110_1100_0101, 12'b0_101_0110_1001,
		12'b0_100_0110_1001, 12'b0_011_0000_0000, 12'b0_010_0000_0000,
		12'b0_001_0000_0000, 12'b1_111_0011_0000, 12'b1_110_1100_0000,
		12'b1_101_0000_0000, 12'b1_100_0000_0000, 12'b1_011_0000_0000,
		12'b1_010_0000_0000, 12'b1_001_0000_0000};

	tacc_control #(.STEP_CYC(4)) uut (.*);
	tacc_panel_model panel (.*);

	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk = ~clk;
	end

	task automatic do_reset;
		@(negedge clk);
		reset_n = 0;
		repeat (20) @(negedge clk);
		reset_n = 1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(negedge clk);
		reg_write = 1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clk);
		reg_write = 0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(negedge clk);
		reg_read = 1;
		reg_addr = a;
		@(negedge clk);
		reg_read = 0;
		@(negedge clk);
		v = reg_rdata;
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Table of single conversions, then reset, alarm, master and power cases.
	initial begin
		do_reset;
		foreach (rows[i]) begin
			slow = i[0];
			wr(`TACC_OFF_POWER, {2'h1, 4'h0, rows[i][11], 9'h040});
			wr(`TACC_OFF_CTRL1, {1'b0, rows[i][10:8], 2'h1, 10'h000});
			`WAIT(adc_start === 1'b1)
			`CHK({adc_start, channel_select}, {1'b1, rows[i][10:8]})
			`CHK({x_pos_drive, x_neg_drive, y_pos_drive, y_neg_drive, ref_pos_sel, ref_neg_sel}, rows[i][7:0])
			`CHK({adc_power, osc_power, bias_power}, 3'h7)
			`WAIT(conv_busy === 1'b0)
			$display("Row %0d done", i);
		end
		do_reset;
		rd(`TACC_OFF_POWER, d);
		`CHK(d, 16'h4040)
		rd(4'h7, d);
		`CHK(d, 16'h0000)
		$display("Reset test done");
		wr(`TACC_OFF_INTSEQ, 16'h20FE);
		wr(`TACC_OFF_CTRL1, 16'h8000);
		touch = 1;
		repeat (10) @(negedge clk);
		`CHK(pen_down_request_n, 1'b1)
		{aux_low_event, aux_high_event, temp_low_event, temp_high_event, gpio_alert_event} = 5'h1F;
		@(negedge clk);
		{aux_low_event, aux_high_event, temp_low_event, temp_high_event, gpio_alert_event} = 5'h00;
		`WAIT(pen_down_request_n === 1'b0)
		`CHK(pen_down_request_n, 1'b0)
		rd(`TACC_OFF_INTSEQ, d);
		`CHK(d[15:1], {8'h3F, 7'h7F})
		touch = 0;
		do_reset;
		$display("Alarm test done");
		wr(`TACC_OFF_POWER, 16'h404A);
		wr(`TACC_OFF_INTSEQ, 16'h00A0);
		wr(`TACC_OFF_CTRL1, 16'h0C00);
		repeat (10) @(negedge clk);
		`CHK({adc_power, osc_power, bias_power, conv_busy}, 4'h0)
		touch = 1;
		t0 = $time;
		`WAIT(pen_down_request_n === 1'b0)
		`CHK(pen_down_request_n, 1'b0)
		`WAIT(adc_start === 1'b1)
		touch = 0;
		`CHK(channel_select, 3'h7)
		`CHK(($time - t0) / 10 inside {[48:64]}, 1'b1)
		`WAIT(adc_done === 1'b1)
		`WAIT(adc_start === 1'b1)
		`CHK({channel_select, x_pos_drive, x_neg_drive, y_pos_drive, y_neg_drive, ref_pos_sel, ref_neg_sel}, 11'h569)
		`WAIT(adc_done === 1'b1)
		t0 = $time;
		`WAIT(conv_busy === 1'b0)
		`CHK(($time - t0) / 10 >= 48, 1'b1)
		wr(`TACC_OFF_CTRL1, 16'h0000);
		$display("Master test done");
		wr(`TACC_OFF_POWER, 16'h0040);
		wr(`TACC_OFF_CTRL1, 16'h0800);
		repeat (50) @(negedge clk);
		`CHK({adc_start, conv_busy, adc_power, osc_power, bias_power, temp_power}, 6'h00)
		wr(`TACC_OFF_POWER, 16'h8040);
		repeat (3) @(negedge clk);
		`CHK({adc_power, osc_power, bias_power}, 3'h7)
		$display("Power test done");
		end_of_test;
	end

	// Cuts a hang short well beyond the expected run time.
	initial begin
		#300000;
		miscompares++;
		$display("Error %0t: watchdog expired", $time);
		end_of_test;
	end
endmodule
